//--- src/cvio_pkg.sv
// package: constants and types shared by both ends of the valve terminal link
package cvio_pkg;
  // ***************************************************************
  // object indices and frame identifiers
  // ***************************************************************
  localparam logic [15:0] OBJ_INPUT_MAPPING_MODE  = 16'h601f;
  localparam logic [15:0] OBJ_OUTPUT_GROUP_STATES = 16'h6200;
  localparam logic [15:0] OBJ_FAULT_HOLD_SELECT   = 16'h6206;
  localparam logic [15:0] OBJ_FAULT_SUBST_VALUES  = 16'h6207;
  localparam logic [10:0] ID_NMT                  = 11'h000;
  localparam logic [10:0] ID_TPDO_BASE            = 11'h180;
  localparam logic [10:0] ID_RPDO_BASE            = 11'h200;
  localparam logic [10:0] ID_SDO_RX_BASE          = 11'h600;
  localparam logic [10:0] ID_SDO_TX_BASE          = 11'h580;
  localparam logic [10:0] ID_BOOTUP_BASE          = 11'h700;
  // ***************************************************************
  // frame lengths and command codes
  // ***************************************************************
  localparam logic [3:0]  LEN_BOOTUP   = 4'h1;
  localparam logic [3:0]  LEN_NMT      = 4'h2;
  localparam logic [3:0]  LEN_RPDO     = 4'h3;
  localparam logic [3:0]  LEN_TPDO     = 4'h4;
  localparam logic [3:0]  LEN_SDO      = 4'h8;
  localparam logic [7:0]  NMT_START    = 8'h01;
  localparam logic [7:0]  NMT_PREOP    = 8'h80;
  localparam logic [7:0]  NMT_RESET    = 8'h81;
  localparam logic [7:0]  NMT_ALL      = 8'h00;
  localparam logic [7:0]  SDO_WR_CMD   = 8'h2f;
  localparam logic [7:0]  SDO_RD_CMD   = 8'h40;
  localparam logic [7:0]  SDO_RD_RESP  = 8'h4f;
  localparam logic [7:0]  SDO_WR_RESP  = 8'h60;
  localparam logic [7:0]  SDO_ABORT    = 8'h80;
  localparam logic [7:0]  GROUP_COUNT  = 8'h03;
  // ***************************************************************
  // input mode codes and reset values
  // ***************************************************************
  localparam logic [7:0]  MODE_NORMAL  = 8'h00;
  localparam logic [7:0]  MODE_SHIFTED = 8'h01;
  localparam logic [7:0]  MODE_HALVED  = 8'h02;
  localparam logic [23:0] OUT_RST      = 24'h000000;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          BLINK_MS      = 200;
  localparam int          BLINK_CYCLES  = CLK_HZ / 1000 * BLINK_MS;
  localparam int          BUS_TMO_MS    = 1500;
  localparam int          BUS_TMO_CYCLES = CLK_HZ / 1000 * BUS_TMO_MS;

  typedef enum logic [1:0] {
    CVIO_INIT,
    CVIO_PREOP,
    CVIO_OPER
  } cvio_nmt_t;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0]  len;
    logic [63:0] data;
  } cvio_frame_t;
endpackage : cvio_pkg

//--- src/cvio_link_if.sv
// interface: frame-level CAN link between master and valve terminal
`timescale 1ns/10ps
interface cvio_link_if;
  import cvio_pkg::*;
  cvio_frame_t m2s_frame;
  logic        m2s_valid;
  logic        m2s_ready;
  cvio_frame_t s2m_frame;
  logic        s2m_valid;
  logic        s2m_ready;

  modport device (
    input  m2s_frame,
    input  m2s_valid,
    output m2s_ready,
    output s2m_frame,
    output s2m_valid,
    input  s2m_ready
  );
  modport master (
    output m2s_frame,
    output m2s_valid,
    input  m2s_ready,
    input  s2m_frame,
    input  s2m_valid,
    output s2m_ready
  );
endinterface : cvio_link_if

//--- src/cvio_device.sv
// valve terminal slave: nmt states, pdo traffic, input mapping, fault reaction
// Contract
// - mode selector defaults 00, 01 with extension
// - normal mode maps inputs sequentially from bit0
// - shifted mode alternates inputs across byte pairs
// - halved mode sends only odd inputs; code sends input bits 0, 2 .. 30 as image bits 0 .. 15
// - three rw output groups, count reads three
// - fault hold bit 1 keeps output state
// - fault hold bit 0 forces substitute value
// - bootup frame 700+node, length 1, zero
// - preoperational flashes bus led green
// - operational lights bus led steady green
// - master starts nodes with 01 00
// - entering operational sends inputs once, 180+node
// - initial input frame sent even when zero
// - pdo 200+node, three bytes set outputs
// - operational sends input frame on change
// - 80 00 returns to preop, no bootup
// - 81 00 resets then preop automatically
`timescale 1ns/10ps
module cvio_device
  import cvio_pkg::*;
#(
  parameter int BUS_TMO = BUS_TMO_CYCLES,
  parameter int BLINK   = BLINK_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  cvio_link_if.device      link,
  input  wire logic [6:0]  i_node_addr,
  input  wire logic        i_input_extension_fitted,
  input  wire logic [31:0] i_inputs,
  output logic [23:0]      o_valves,
  output logic             o_led_green,
  output logic             o_bus_fault,
  output logic [1:0]       o_nmt_state
);
  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [31:0] in_s1_q, in_s2_q;
  logic [6:0]  adr_s1_q, adr_s2_q;
  logic        ext_s1_q, ext_s2_q;
  always_ff @(posedge i_clk) begin
    in_s1_q  <= i_inputs;
    in_s2_q  <= in_s1_q;
    adr_s1_q <= i_node_addr;
    adr_s2_q <= adr_s1_q;
    ext_s1_q <= i_input_extension_fitted;
    ext_s2_q <= ext_s1_q;
  end

  cvio_nmt_t   nmt_q;
  logic [7:0]  mode_q;
  logic [23:0] out_q, hold_q, subst_q, valve_q;
  logic [31:0] image_d, sent_q;
  logic        fault_q, boot_pend_q, first_pend_q, tx_busy_q;
  logic [31:0] tmo_q, blink_q;
  logic        led_q;
  cvio_frame_t tx_q;
  cvio_frame_t sdo_rsp;

  wire cvio_frame_t rx   = link.m2s_frame;
  wire logic        rx_v = link.m2s_valid;
  assign link.m2s_ready = 1'b1;
  wire logic tx_done = tx_busy_q && link.s2m_ready;
  wire logic [10:0] node_id = {4'h0, adr_s2_q};

  wire logic nmt_hit = rx_v && rx.id == ID_NMT && rx.len == LEN_NMT
                       && (rx.data[55:48] == NMT_ALL || rx.data[55:48] == {1'b0, adr_s2_q});
  wire logic [7:0] nmt_cmd = rx.data[63:56];
  wire logic rpdo_hit = rx_v && rx.id == ID_RPDO_BASE + node_id && rx.len == LEN_RPDO;
  wire logic sdo_hit  = rx_v && rx.id == ID_SDO_RX_BASE + node_id && rx.len == LEN_SDO;
  wire logic [7:0]  sdo_cmd = rx.data[63:56];
  wire logic [15:0] sdo_idx = {rx.data[47:40], rx.data[55:48]};
  wire logic [7:0]  sdo_sub = rx.data[39:32];
  wire logic [7:0]  sdo_val = rx.data[31:24];
  wire logic sdo_wr = sdo_hit && sdo_cmd == SDO_WR_CMD && sdo_sub >= 8'h01
                      && sdo_sub <= GROUP_COUNT;

  // ***************************************************************
  // network state machine
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      nmt_q <= CVIO_INIT;
    end else begin
      case (nmt_q)
        CVIO_INIT:  nmt_q <= CVIO_PREOP;
        CVIO_PREOP: begin
          if (nmt_hit && nmt_cmd == NMT_START) nmt_q <= CVIO_OPER;
          else if (nmt_hit && nmt_cmd == NMT_RESET) nmt_q <= CVIO_INIT;
        end
        CVIO_OPER: begin
          if (nmt_hit && nmt_cmd == NMT_PREOP) nmt_q <= CVIO_PREOP;
          else if (nmt_hit && nmt_cmd == NMT_RESET) nmt_q <= CVIO_INIT;
        end
        default: nmt_q <= CVIO_INIT;
      endcase
    end
  end

  // ***************************************************************
  // object dictionary registers
  // ***************************************************************
  // mode default is taken from the strap while held in init, including under reset
  always_ff @(posedge i_clk) begin
    if (nmt_q == CVIO_INIT) begin
      mode_q <= ext_s2_q ? MODE_SHIFTED : MODE_NORMAL;
    end else if (sdo_hit && sdo_cmd == SDO_WR_CMD && sdo_idx == OBJ_INPUT_MAPPING_MODE
                 && sdo_sub == 8'h00
                 && (sdo_val == MODE_NORMAL || sdo_val == MODE_SHIFTED
                     || sdo_val == MODE_HALVED)) begin
      mode_q <= sdo_val;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_q   <= OUT_RST;
      hold_q  <= OUT_RST;
      subst_q <= OUT_RST;
    end else if (rpdo_hit && nmt_q == CVIO_OPER) begin
      out_q <= {rx.data[47:40], rx.data[55:48], rx.data[63:56]};
    end else if (sdo_wr) begin
      case (sdo_idx)
        OBJ_OUTPUT_GROUP_STATES: out_q[8*(sdo_sub-8'h01) +: 8]   <= sdo_val;
        OBJ_FAULT_HOLD_SELECT:   hold_q[8*(sdo_sub-8'h01) +: 8]  <= sdo_val;
        OBJ_FAULT_SUBST_VALUES:  subst_q[8*(sdo_sub-8'h01) +: 8] <= sdo_val;
        default: ;
      endcase
    end
  end

  // sdo answer; unknown objects get an abort so the master never hangs
  always_comb begin
    logic [23:0] src;
    logic        ok;
    src = OUT_RST;
    ok  = 1'b1;
    case (sdo_idx)
      OBJ_OUTPUT_GROUP_STATES: src = out_q;
      OBJ_FAULT_HOLD_SELECT:   src = hold_q;
      OBJ_FAULT_SUBST_VALUES:  src = subst_q;
      OBJ_INPUT_MAPPING_MODE:  src = {16'h0000, mode_q};
      default:                 ok  = 1'b0;
    endcase
    sdo_rsp = '0;
    sdo_rsp.id  = ID_SDO_TX_BASE + node_id;
    sdo_rsp.len = LEN_SDO;
    sdo_rsp.data[55:32] = rx.data[55:32];
    if (!ok || (sdo_idx != OBJ_INPUT_MAPPING_MODE && sdo_sub > GROUP_COUNT)
        || (sdo_idx == OBJ_INPUT_MAPPING_MODE && sdo_sub != 8'h00)) begin
      sdo_rsp.data[63:56] = SDO_ABORT;
    end else if (sdo_cmd == SDO_WR_CMD) begin
      sdo_rsp.data[63:56] = SDO_WR_RESP;
    end else begin
      sdo_rsp.data[63:56] = SDO_RD_RESP;
      if (sdo_idx == OBJ_INPUT_MAPPING_MODE) sdo_rsp.data[31:24] = src[7:0];
      else if (sdo_sub == 8'h00) sdo_rsp.data[31:24] = GROUP_COUNT;
      else sdo_rsp.data[31:24] = src[8*(sdo_sub-8'h01) +: 8];
    end
  end

  // ***************************************************************
  // input mapping
  // ***************************************************************
  always_comb begin
    image_d = 32'h00000000;
    for (int i = 0; i < 16; i++) begin
      case (mode_q)
        MODE_SHIFTED: begin
          image_d[(i%2)*8 + i/2]      = in_s2_q[i];
          image_d[16 + (i%2)*8 + i/2] = in_s2_q[16+i];
        end
        MODE_HALVED: image_d[i] = in_s2_q[2*i];
        default: begin
          image_d[i]    = in_s2_q[i];
          image_d[16+i] = in_s2_q[16+i];
        end
      endcase
    end
  end

  // ***************************************************************
  // fault detection and valve drive
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst || rx_v) begin
      tmo_q   <= 32'h00000000;
      fault_q <= 1'b0;
    end else if (nmt_q == CVIO_OPER && tmo_q < BUS_TMO) begin
      tmo_q <= tmo_q + 32'h00000001;
    end else if (nmt_q == CVIO_OPER) begin
      fault_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      valve_q <= OUT_RST;
    end else if (!fault_q) begin
      valve_q <= out_q;
    end else begin
      valve_q <= (hold_q & valve_q) | (~hold_q & subst_q);
    end
  end
  assign o_valves    = valve_q;
  assign o_bus_fault = fault_q;
  assign o_nmt_state = nmt_q;

  // ***************************************************************
  // transmit scheduling
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      boot_pend_q  <= 1'b0;
      first_pend_q <= 1'b0;
    end else begin
      if (nmt_q == CVIO_INIT) boot_pend_q <= 1'b1;
      else if (tx_done && tx_q.id == ID_BOOTUP_BASE + node_id) boot_pend_q <= 1'b0;
      if (nmt_q == CVIO_PREOP && nmt_hit && nmt_cmd == NMT_START) first_pend_q <= 1'b1;
      else if (tx_done && tx_q.id == ID_TPDO_BASE + node_id) first_pend_q <= 1'b0;
    end
  end

  // sdo answers share the one transmit slot; a request arriving while busy is dropped
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_busy_q <= 1'b0;
      tx_q      <= '0;
      sent_q    <= 32'h00000000;
    end else if (tx_busy_q) begin
      if (link.s2m_ready) tx_busy_q <= 1'b0;
    end else if (sdo_hit) begin
      tx_busy_q <= 1'b1;
      tx_q      <= sdo_rsp;
    end else if (boot_pend_q && nmt_q == CVIO_PREOP) begin
      tx_busy_q <= 1'b1;
      tx_q.id   <= ID_BOOTUP_BASE + node_id;
      tx_q.len  <= LEN_BOOTUP;
      tx_q.data <= 64'h0000000000000000;
    end else if (nmt_q == CVIO_OPER && (first_pend_q || image_d != sent_q)) begin
      tx_busy_q <= 1'b1;
      tx_q.id   <= ID_TPDO_BASE + node_id;
      tx_q.len  <= LEN_TPDO;
      tx_q.data <= {image_d[7:0], image_d[15:8], image_d[23:16], image_d[31:24], 32'h00000000};
      sent_q    <= image_d;
    end
  end
  assign link.s2m_valid = tx_busy_q;
  assign link.s2m_frame = tx_q;

  // ***************************************************************
  // bus led
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst || nmt_q != CVIO_PREOP) begin
      blink_q <= 32'h00000000;
      led_q   <= 1'b0;
    end else if (blink_q >= BLINK - 1) begin
      blink_q <= 32'h00000000;
      led_q   <= ~led_q;
    end else begin
      blink_q <= blink_q + 32'h00000001;
    end
  end
  assign o_led_green = (nmt_q == CVIO_OPER) ? 1'b1 : led_q;
endmodule : cvio_device

//--- src/cvio_master.sv
// master end: issues nmt commands, output pdos and sdo accesses on user request
`timescale 1ns/10ps
module cvio_master
  import cvio_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  cvio_link_if.master      link,
  input  wire logic        i_req,
  input  wire logic [1:0]  i_kind,
  input  wire logic [6:0]  i_node_addr,
  input  wire logic [7:0]  i_nmt_cmd,
  input  wire logic [23:0] i_outputs,
  input  wire logic [63:0] i_sdo_data,
  output logic             o_busy,
  output logic             o_rx_valid,
  output cvio_frame_t      o_rx_frame
);
  logic        busy_q;
  cvio_frame_t tx_q;
  logic        rxv_q;
  cvio_frame_t rx_q;
  wire logic [10:0] node_id = {4'h0, i_node_addr};

  // kind: 0 nmt, 1 output pdo, 2 sdo request
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      tx_q   <= '0;
    end else if (busy_q) begin
      if (link.m2s_ready) busy_q <= 1'b0;
    end else if (i_req) begin
      busy_q <= 1'b1;
      case (i_kind)
        2'd0: begin
          tx_q.id   <= ID_NMT;
          tx_q.len  <= LEN_NMT;
          tx_q.data <= {i_nmt_cmd, NMT_ALL, 48'h000000000000};
        end
        2'd1: begin
          tx_q.id   <= ID_RPDO_BASE + node_id;
          tx_q.len  <= LEN_RPDO;
          tx_q.data <= {i_outputs[7:0], i_outputs[15:8], i_outputs[23:16], 40'h0000000000};
        end
        default: begin
          tx_q.id   <= ID_SDO_RX_BASE + node_id;
          tx_q.len  <= LEN_SDO;
          tx_q.data <= i_sdo_data;
        end
      endcase
    end
  end
  assign link.m2s_valid = busy_q;
  assign link.m2s_frame = tx_q;
  assign o_busy         = busy_q;
  assign link.s2m_ready = 1'b1;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rxv_q <= 1'b0;
      rx_q  <= '0;
    end else begin
      rxv_q <= link.s2m_valid;
      if (link.s2m_valid) rx_q <= link.s2m_frame;
    end
  end
  assign o_rx_valid = rxv_q;
  assign o_rx_frame = rx_q;
endmodule : cvio_master

//--- verif/cvio_assertions.sv
// checker: concurrent properties on the master to valve terminal frame link
`timescale 1ns/10ps
module cvio_assertions
  import cvio_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire cvio_frame_t m2s_frame,
  input wire logic        m2s_valid,
  input wire logic        m2s_ready,
  input wire cvio_frame_t s2m_frame,
  input wire logic        s2m_valid,
  input wire logic        s2m_ready
);
  // ***************************************************************
  // frame classes, node bits masked off
  // ***************************************************************
  logic        tx_boot, tx_tpdo, tx_sdo, rx_nmt, rx_rpdo, rx_sdo;
  logic [15:0] nmt_cmd;
  assign tx_boot = s2m_valid && ((s2m_frame.id & 11'h780) == ID_BOOTUP_BASE);
  assign tx_tpdo = s2m_valid && ((s2m_frame.id & 11'h780) == ID_TPDO_BASE);
  assign tx_sdo  = s2m_valid && ((s2m_frame.id & 11'h780) == ID_SDO_TX_BASE);
  assign rx_nmt  = m2s_valid && m2s_ready && (m2s_frame.id == ID_NMT);
  assign rx_rpdo = m2s_valid && m2s_ready && ((m2s_frame.id & 11'h780) == ID_RPDO_BASE);
  assign rx_sdo  = m2s_valid && m2s_ready && ((m2s_frame.id & 11'h780) == ID_SDO_RX_BASE);
  assign nmt_cmd = rx_nmt ? m2s_frame.data[63:48] : 16'hffff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ***************************************************************
  // properties
  // ***************************************************************
  chk_bootup_after_rst: assert property ($fell(i_rst) |-> ##[0:3] tx_boot)
    else $error("no boot-up frame after reset release");
  chk_bootup_frame_form: assert property (tx_boot |->
    s2m_frame.len == LEN_BOOTUP && s2m_frame.data[63:56] == 8'h00)
    else $error("boot-up frame malformed");
  chk_start_sends_inputs: assert property (
    nmt_cmd == {NMT_START, NMT_ALL} |-> ##[1:3] tx_tpdo)
    else $error("no input frame on entering operational");
  chk_input_frame_len: assert property (tx_tpdo |-> s2m_frame.len == LEN_TPDO)
    else $error("input frame length wrong");
  chk_preop_no_bootup: assert property (nmt_cmd == {NMT_PREOP, NMT_ALL} |=> !tx_boot [*8])
    else $error("boot-up frame after return to pre-operational");
  chk_reset_node_bootup: assert property (
    nmt_cmd == {NMT_RESET, NMT_ALL} |-> ##[1:6] tx_boot)
    else $error("no boot-up frame after node reset");
  chk_output_pdo_len: assert property (rx_rpdo |-> m2s_frame.len == LEN_RPDO)
    else $error("output frame length wrong");
  chk_nmt_frame_len: assert property (rx_nmt |-> m2s_frame.len == LEN_NMT)
    else $error("command frame length wrong");
  chk_object_reply_due: assert property (rx_sdo |-> ##[1:4] tx_sdo)
    else $error("object access left unanswered");
  cover property (tx_tpdo && s2m_ready);
  cover property (nmt_cmd == {NMT_RESET, NMT_ALL});
  cover property (rx_rpdo ##[1:4] !rx_rpdo);
endmodule : cvio_assertions

//--- verif/tb.sv
// testbench: master end and valve terminal joined over the frame link
`timescale 1ns/10ps
module tb;
  import cvio_pkg::*;
  typedef struct packed {
    logic [7:0]  mode;
    logic [31:0] pins;
    logic [31:0] img;
  } cvio_row_t;
  localparam logic [6:0]  NODE = 7'h05;
  localparam logic [63:0] M1   = 64'hff00_0000_0000_0000;
  localparam logic [63:0] M4   = 64'hffff_ffff_0000_0000;
  localparam logic [63:0] M5   = 64'hffff_ffff_ff00_0000;
  logic        i_clk, i_rst, i_req, strap, led, fault, o_busy, o_rx_valid;
  logic [1:0]  i_kind, nmt_state;
  logic [7:0]  i_nmt_cmd;
  logic [23:0] i_outputs, valves;
  logic [63:0] i_sdo_data;
  logic [31:0] pins;
  cvio_frame_t o_rx_frame, f;
  cvio_frame_t rxq[$];
  int          errors, n_compared, k;
  cvio_row_t   rows[4] = '{'{MODE_NORMAL, 32'h8000_0101, 32'h8000_0101},
    '{MODE_SHIFTED, 32'h0000_0002, 32'h0000_0100}, '{MODE_SHIFTED, 32'h0001_0004, 32'h0001_0002},
    '{MODE_HALVED, 32'hc000_0005, 32'h0000_8003}};
  cvio_link_if cvio_link_if_inst ();
  cvio_device #(.BUS_TMO(50), .BLINK(4)) cvio_device_inst (.i_clk(i_clk), .i_rst(i_rst),
    .link(cvio_link_if_inst), .i_node_addr(NODE), .i_input_extension_fitted(strap),
    .i_inputs(pins), .o_valves(valves), .o_led_green(led), .o_bus_fault(fault),
    .o_nmt_state(nmt_state));
  cvio_master cvio_master_inst (.i_clk(i_clk), .i_rst(i_rst), .link(cvio_link_if_inst),
    .i_req(i_req), .i_kind(i_kind), .i_node_addr(NODE), .i_nmt_cmd(i_nmt_cmd),
    .i_outputs(i_outputs), .i_sdo_data(i_sdo_data), .o_busy(o_busy),
    .o_rx_valid(o_rx_valid), .o_rx_frame(o_rx_frame));
  cvio_assertions cvio_assertions_inst (.i_clk(i_clk), .i_rst(i_rst),
    .m2s_frame(cvio_link_if_inst.m2s_frame), .m2s_valid(cvio_link_if_inst.m2s_valid),
    .m2s_ready(cvio_link_if_inst.m2s_ready), .s2m_frame(cvio_link_if_inst.s2m_frame),
    .s2m_valid(cvio_link_if_inst.s2m_valid), .s2m_ready(cvio_link_if_inst.s2m_ready));
  // ***************************************************************
  // clock, frame monitor, watchdog
  // ***************************************************************
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (o_rx_valid === 1'b1) rxq.push_back(o_rx_frame);
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [63:0] sdo_d(input logic [7:0] c, input logic [15:0] idx,
                                        input logic [7:0] sub, input logic [7:0] v);
    return {c, idx[7:0], idx[15:8], sub, v, 24'h0};
  endfunction : sdo_d
  task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp_v
  task automatic cmp_f(input cvio_frame_t g, input logic [10:0] id, input logic [3:0] len,
                       input logic [63:0] d, input logic [63:0] m);
    n_compared++;
    if (g.id !== id || g.len !== len || (g.data & m) !== (d & m)) begin
      errors++;
      $display("[ERR] %0t frame %h/%h/%h expected %h/%h/%h", $time, g.id, g.len, g.data,
               id, len, d);
    end
  endtask : cmp_f
  task automatic get_f();
    k = 0;
    while (rxq.size() == 0 && k < 40) begin
      @(posedge i_clk);
      k++;
    end
    f = (rxq.size() != 0) ? rxq.pop_front() : '0;
  endtask : get_f
  task automatic send(input logic [1:0] kind, input logic [7:0] cmd, input logic [23:0] outs,
                      input logic [63:0] sd);
    k = 0;
    while (o_busy !== 1'b0 && k < 50) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 50) begin
      errors++;
      $display("[ERR] %0t master stayed busy", $time);
    end
    i_kind     <= kind;
    i_nmt_cmd  <= cmd;
    i_outputs  <= outs;
    i_sdo_data <= sd;
    i_req      <= 1'b1;
    @(posedge i_clk);
    i_req <= 1'b0;
    @(posedge i_clk);
  endtask : send
  task automatic sdo(input logic [7:0] c, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [7:0] v);
    send(2'd2, 8'h00, 24'h0, sdo_d(c, idx, sub, v));
    get_f();
  endtask : sdo
  task automatic complete_run();
    $display("errors %0d n_compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {i_rst, i_req, i_kind, i_nmt_cmd, i_outputs, i_sdo_data, pins, strap} = '0;
    i_rst = 1'b1;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    get_f();
    cmp_f(f, 11'h705, LEN_BOOTUP, 64'h0, M1);
    cmp_v(32'(nmt_state), 32'h1);
    sdo(SDO_RD_CMD, 16'h601f, 8'h00, 8'h00);
    cmp_f(f, 11'h585, LEN_SDO, sdo_d(SDO_RD_RESP, 16'h601f, 8'h00, 8'h00), M5);
    sdo(SDO_RD_CMD, 16'h6200, 8'h00, 8'h00);
    cmp_f(f, 11'h585, LEN_SDO, sdo_d(SDO_RD_RESP, 16'h6200, 8'h00, 8'h03), M5);
    k = 0;
    repeat (12) @(posedge i_clk) k += int'(led === 1'b1);
    cmp_v({31'h0, k > 0 && k < 12}, 32'h1);
    send(2'd1, 8'h00, 24'hffffff, 64'h0);
    repeat (4) @(posedge i_clk);
    cmp_v({8'h0, valves}, 32'h0);
    send(2'd0, NMT_START, 24'h0, 64'h0);
    get_f();
    cmp_f(f, 11'h185, LEN_TPDO, 64'h0, M4);
    cmp_v(32'(nmt_state), 32'h2);
    k = 0;
    repeat (12) @(posedge i_clk) k += int'(led === 1'b1);
    cmp_v(32'(k), 32'd12);
    send(2'd1, 8'h00, 24'h563412, 64'h0);
    repeat (4) @(posedge i_clk);
    cmp_v({8'h0, valves}, 32'h0056_3412);
    sdo(SDO_RD_CMD, 16'h6200, 8'h01, 8'h00);
    cmp_f(f, 11'h585, LEN_SDO, sdo_d(SDO_RD_RESP, 16'h6200, 8'h01, 8'h12), M5);
    sdo(SDO_RD_CMD, 16'h6200, 8'h04, 8'h00);
    cmp_f(f, 11'h585, LEN_SDO, sdo_d(SDO_ABORT, 16'h6200, 8'h04, 8'h00), M4);
    sdo(SDO_WR_CMD, 16'h6200, 8'h03, 8'h9c);
    cmp_v({8'h0, valves}, 32'h009c_3412);
    foreach (rows[i]) begin
      sdo(SDO_WR_CMD, 16'h601f, 8'h00, rows[i].mode);
      cmp_f(f, 11'h585, LEN_SDO, sdo_d(SDO_WR_RESP, 16'h601f, 8'h00, 8'h00), M4);
      pins <= rows[i].pins;
      get_f();
      cmp_f(f, 11'h185, LEN_TPDO, {rows[i].img[7:0], rows[i].img[15:8], rows[i].img[23:16],
            rows[i].img[31:24], 32'h0}, M4);
      pins <= 32'h0;
      get_f();
      cmp_f(f, 11'h185, LEN_TPDO, 64'h0, M4);
    end
    sdo(SDO_WR_CMD, 16'h601f, 8'h00, 8'h07);
    sdo(SDO_RD_CMD, 16'h601f, 8'h00, 8'h00);
    cmp_f(f, 11'h585, LEN_SDO, sdo_d(SDO_RD_RESP, 16'h601f, 8'h00, MODE_HALVED), M5);
    sdo(SDO_WR_CMD, 16'h6206, 8'h01, 8'hf0);
    sdo(SDO_WR_CMD, 16'h6207, 8'h01, 8'h05);
    send(2'd1, 8'h00, 24'h0000aa, 64'h0);
    repeat (70) @(posedge i_clk);
    cmp_v({31'h0, fault}, 32'h1);
    cmp_v({24'h0, valves[7:0]}, 32'h0000_00a5);
    send(2'd0, NMT_PREOP, 24'h0, 64'h0);
    repeat (10) @(posedge i_clk);
    cmp_v(32'(rxq.size()), 32'h0);
    cmp_v({29'h0, fault, nmt_state}, 32'h1);
    strap <= 1'b1;
    repeat (4) @(posedge i_clk);
    send(2'd0, NMT_RESET, 24'h0, 64'h0);
    get_f();
    cmp_f(f, 11'h705, LEN_BOOTUP, 64'h0, M1);
    sdo(SDO_RD_CMD, 16'h601f, 8'h00, 8'h00);
    cmp_f(f, 11'h585, LEN_SDO, sdo_d(SDO_RD_RESP, 16'h601f, 8'h00, MODE_SHIFTED), M5);
    send(2'd0, NMT_START, 24'h0, 64'h0);
    get_f();
    cmp_f(f, 11'h185, LEN_TPDO, 64'h0, M4);
    complete_run();
  end
endmodule : tb
